/* File: design/bfc_pkg.sv */
// Shared constants and types of the branch and flow-control unit
`default_nettype none
package bfc_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD  = 8'h00;
    localparam logic [7:0] ADDR_OPND = 8'h04;
    localparam logic [7:0] ADDR_PTR  = 8'h08;
    localparam logic [7:0] ADDR_PC   = 8'h0C;
    localparam logic [7:0] ADDR_FLG  = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_BIT_LSB  = 8;
    localparam int CMD_TWO_POS  = 12;
    localparam int CMD_K_LSB    = 16;
    localparam int OPND_RD_LSB  = 0;
    localparam int OPND_RR_LSB  = 8;
    localparam int OPND_IO_LSB  = 16;
    localparam int PTR_Z_LSB    = 0;
    localparam int PTR_STK_LSB  = 16;
    localparam int STAT_BSY_POS = 0;
    localparam int STAT_CYC_LSB = 4;
    localparam int STAT_LNK_LSB = 16;

    // Status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // ----------------------------------------------------------------
    // Reset values and cycle counts
    // ----------------------------------------------------------------
    localparam logic [15:0] PC_RST   = 16'h0000;
    localparam logic [7:0]  FLG_RST  = 8'h00;
    localparam logic [2:0]  CYC_ONE   = 3'd1;
    localparam logic [2:0]  CYC_TWO   = 3'd2;
    localparam logic [2:0]  CYC_THREE = 3'd3;
    localparam logic [2:0]  CYC_FOUR  = 3'd4;

    // Operation codes
    typedef enum logic [4:0] {
        relative_jump_op,         indirect_jump_op,       relative_call_op,
        indirect_call_op,         subroutine_return_op,   interrupt_return_op,
        compare_skip_equal_op,    compare_regs_op,        compare_regs_carry_op,
        compare_immediate_op,     skip_reg_bit_clear_op,  skip_reg_bit_set_op,
        skip_io_bit_clear_op,     skip_io_bit_set_op,     branch_flag_set_op,
        branch_flag_clear_op,     branch_equal_op,        branch_not_equal_op,
        branch_carry_set_op,      branch_carry_clear_op,  branch_same_higher_op,
        branch_lower_op,          branch_minus_op,        branch_plus_op,
        branch_signed_ge_op,      branch_signed_lt_op,    branch_half_carry_set_op,
        branch_half_carry_clear_op, branch_tbit_set_op,   branch_tbit_clear_op,
        branch_overflow_set_op,   branch_overflow_clear_op
    } bfc_op_e;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } bfc_state_e;

endpackage : bfc_pkg
`default_nettype wire

/* File: design/bfc_cmp.sv */
// Compare unit: difference flags without storing the result
`timescale 1ns/1ps
`default_nettype none
module bfc_cmp (
    // Operands
    input  wire logic [7:0] rd,
    input  wire logic [7:0] rr,
    input  wire logic       cin,
    input  wire logic       zin,
    input  wire logic       use_carry,
    // Flags
    output logic            z,
    output logic            n,
    output logic            v,
    output logic            c,
    output logic            h
);
    logic [8:0] diff;

    // Subtract with optional borrow in; result is only used for flags
    always_comb begin
        diff = {1'b0, rd} - {1'b0, rr} - {8'h00, use_carry & cin};
        c = diff[8];
        n = diff[7];
        v = (rd[7] & ~rr[7] & ~diff[7]) | (~rd[7] & rr[7] & diff[7]);
        h = (~rd[3] & rr[3]) | (rr[3] & diff[3]) | (diff[3] & ~rd[3]);
        // With carry, zero is sticky so multi-byte compares chain
        z = (diff[7:0] == 8'h00) & (use_carry ? zin : 1'b1);
    end
endmodule : bfc_cmp
`default_nettype wire

/* File: design/bfc_cond.sv */
// Condition evaluator for branches and skips
`timescale 1ns/1ps
`default_nettype none
module bfc_cond (
    // Instruction
    input  wire logic [4:0] op,
    input  wire logic [2:0] bit_sel,
    // Operands
    input  wire logic [7:0] flags,
    input  wire logic [7:0] rd,
    input  wire logic [7:0] rr,
    input  wire logic [7:0] io,
    // Result
    output logic            is_branch,
    output logic            is_skip,
    output logic            taken
);

    // Branches test one status flag, signed ones N xor V; skips test a register bit, an I/O bit or equality
    always_comb begin
        is_branch = 1'b1;
        is_skip   = 1'b0;
        taken     = 1'b0;
        unique case (op)
            bfc_pkg::branch_flag_set_op:         taken = flags[bit_sel];
            bfc_pkg::branch_flag_clear_op:       taken = ~flags[bit_sel];
            bfc_pkg::branch_equal_op:            taken = flags[bfc_pkg::FLAG_Z];
            bfc_pkg::branch_not_equal_op:        taken = ~flags[bfc_pkg::FLAG_Z];
            bfc_pkg::branch_carry_set_op,
            bfc_pkg::branch_lower_op:            taken = flags[bfc_pkg::FLAG_C];
            bfc_pkg::branch_carry_clear_op,
            bfc_pkg::branch_same_higher_op:      taken = ~flags[bfc_pkg::FLAG_C];
            bfc_pkg::branch_minus_op:            taken = flags[bfc_pkg::FLAG_N];
            bfc_pkg::branch_plus_op:             taken = ~flags[bfc_pkg::FLAG_N];
            bfc_pkg::branch_signed_ge_op:        taken = ~(flags[bfc_pkg::FLAG_N]
                                                     ^ flags[bfc_pkg::FLAG_V]);
            bfc_pkg::branch_signed_lt_op:        taken = flags[bfc_pkg::FLAG_N]
                                                     ^ flags[bfc_pkg::FLAG_V];
            bfc_pkg::branch_half_carry_set_op:   taken = flags[bfc_pkg::FLAG_H];
            bfc_pkg::branch_half_carry_clear_op: taken = ~flags[bfc_pkg::FLAG_H];
            bfc_pkg::branch_tbit_set_op:         taken = flags[bfc_pkg::FLAG_T];
            bfc_pkg::branch_tbit_clear_op:       taken = ~flags[bfc_pkg::FLAG_T];
            bfc_pkg::branch_overflow_set_op:     taken = flags[bfc_pkg::FLAG_V];
            bfc_pkg::branch_overflow_clear_op:   taken = ~flags[bfc_pkg::FLAG_V];
            bfc_pkg::compare_skip_equal_op: begin
                is_branch = 1'b0;
                is_skip   = 1'b1;
                taken     = (rd == rr);
            end
            bfc_pkg::skip_reg_bit_clear_op, bfc_pkg::skip_reg_bit_set_op: begin
                is_branch = 1'b0;
                is_skip   = 1'b1;
                taken     = rr[bit_sel] ^ (op == bfc_pkg::skip_reg_bit_clear_op);
            end
            bfc_pkg::skip_io_bit_clear_op, bfc_pkg::skip_io_bit_set_op: begin
                is_branch = 1'b0;
                is_skip   = 1'b1;
                taken     = io[bit_sel] ^ (op == bfc_pkg::skip_io_bit_clear_op);
            end
            default: is_branch = 1'b0;
        endcase
    end
endmodule : bfc_cond
`default_nettype wire

/* File: design/bfc_flow.sv */
// Branch, compare and flow-control unit with an AHB-Lite register slave
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Taken relative branch loads PC plus offset plus one; 1 or 2 cycles, no flags.
// - Indirect jump loads PC from Z pointer, flags kept, 2 cycles.
// - Indirect call loads PC from Z pointer as a call, flags kept, 3 cycles.
// - Compare-skip-equal advances PC by 2 or 3 on equal; 1, 2 or 3 cycles.
// - Compares update Z, N, V, C, H without storing difference, 1 cycle.
// - Register bit tests skip on bit clear or set; 1, 2 or 3 cycles.
// - I/O bit tests skip on bit 0 or 1; 1, 2 or 3 cycles, no flags.
// - Generic flag branches test the indexed status bit for 1 or 0.
// - Carry branches taken on C set or C clear.
// - Signed branches use N xor V: 0 for greater-equal, 1 for less-than.
// - Sign branches taken on N set or N clear.
// - Half-carry branches taken on H set or clear.
// - Transfer-bit branches taken on T set or clear.
// - Overflow branches taken on V set or clear.
module bfc_flow (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite address phase
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    // AHB-Lite data phase
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);
    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic        wr_pend_r;
    logic        rd_pend_r;
    logic [7:0]  acc_addr_r;
    logic [31:0] hrdata_r;
    logic        hreadyout_r;
    logic        addr_ok;

    // Only word-sized transfers exist; size is not decoded
    assign addr_ok = hsel & htrans[1] & hready;

    // Address phase capture; reads take one wait state so data is current
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r   <= 1'b0;
            rd_pend_r   <= 1'b0;
            acc_addr_r  <= 8'h00;
            hreadyout_r <= 1'b1;
        end else begin
            wr_pend_r   <= addr_ok & hwrite;
            rd_pend_r   <= addr_ok & ~hwrite;
            hreadyout_r <= ~(addr_ok & ~hwrite);
            if (addr_ok) begin
                acc_addr_r <= haddr[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Architectural state
    // ----------------------------------------------------------------
    bfc_pkg::bfc_state_e state_r;
    logic [4:0]  op_r;
    logic [2:0]  bit_r;
    logic        two_r;
    logic [11:0] k_r;
    logic [7:0]  rd_r, rr_r, io_r;
    logic [15:0] z_r, stk_r, pc_r, link_r;
    logic [7:0]  flags_r;
    logic [2:0]  cnt_r, last_cyc_r;
    logic        busy;
    logic        cmd_wr;
    logic        done;

    assign busy   = (state_r == bfc_pkg::ST_EXEC);
    assign cmd_wr = wr_pend_r & (acc_addr_r == bfc_pkg::ADDR_CMD) & ~busy;

    // ----------------------------------------------------------------
    // Decode and next values
    // ----------------------------------------------------------------
    logic        is_branch, is_skip, taken;
    logic        is_cmp;
    logic        cz, cn, cv, cc, ch;
    logic [2:0]  need;
    logic [15:0] pc_nxt, rel_tgt;
    logic [7:0]  flags_nxt;

    bfc_cond u_cond (
        .op        (op_r),
        .bit_sel   (bit_r),
        .flags     (flags_r),
        .rd        (rd_r),
        .rr        (rr_r),
        .io        (io_r),
        .is_branch (is_branch),
        .is_skip   (is_skip),
        .taken     (taken)
    );

    bfc_cmp u_cmp (
        .rd        (rd_r),
        .rr        (rr_r),
        .cin       (flags_r[bfc_pkg::FLAG_C]),
        .zin       (flags_r[bfc_pkg::FLAG_Z]),
        .use_carry (op_r == bfc_pkg::compare_regs_carry_op),
        .z         (cz),
        .n         (cn),
        .v         (cv),
        .c         (cc),
        .h         (ch)
    );

    assign is_cmp  = (op_r == bfc_pkg::compare_regs_op)
                   | (op_r == bfc_pkg::compare_regs_carry_op)
                   | (op_r == bfc_pkg::compare_immediate_op);
    assign rel_tgt = pc_r + {{4{k_r[11]}}, k_r} + 16'h0001;

    // Cycle count, new program counter and new flags per operation
    always_comb begin
        need     = bfc_pkg::CYC_ONE;
        pc_nxt   = pc_r + 16'h0001;
        flags_nxt = flags_r;
        unique case (op_r)
            bfc_pkg::relative_jump_op: begin
                need   = bfc_pkg::CYC_TWO;
                pc_nxt = rel_tgt;
            end
            bfc_pkg::relative_call_op: begin
                need   = bfc_pkg::CYC_THREE;
                pc_nxt = rel_tgt;
            end
            bfc_pkg::indirect_jump_op: begin
                need   = bfc_pkg::CYC_TWO;
                pc_nxt = z_r;
            end
            bfc_pkg::indirect_call_op: begin
                need   = bfc_pkg::CYC_THREE;
                pc_nxt = z_r;
            end
            bfc_pkg::subroutine_return_op: begin
                need   = bfc_pkg::CYC_FOUR;
                pc_nxt = stk_r;
            end
            bfc_pkg::interrupt_return_op: begin
                need   = bfc_pkg::CYC_FOUR;
                pc_nxt = stk_r;
                flags_nxt[bfc_pkg::FLAG_I] = 1'b1;
            end
            bfc_pkg::compare_regs_op, bfc_pkg::compare_regs_carry_op,
            bfc_pkg::compare_immediate_op: begin
                flags_nxt[bfc_pkg::FLAG_Z] = cz;
                flags_nxt[bfc_pkg::FLAG_N] = cn;
                flags_nxt[bfc_pkg::FLAG_V] = cv;
                flags_nxt[bfc_pkg::FLAG_C] = cc;
                flags_nxt[bfc_pkg::FLAG_H] = ch;
            end
            default: begin
                if (is_branch && taken) begin
                    need   = bfc_pkg::CYC_TWO;
                    pc_nxt = rel_tgt;
                end else if (is_skip && taken) begin
                    // Skip length follows the size of the skipped instruction
                    need   = two_r ? bfc_pkg::CYC_THREE : bfc_pkg::CYC_TWO;
                    pc_nxt = pc_r + (two_r ? 16'h0003 : 16'h0002);
                end
            end
        endcase
    end

    assign done = busy & (cnt_r == need);

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r    <= bfc_pkg::ST_IDLE;
            cnt_r      <= 3'd0;
            last_cyc_r <= 3'd0;
        end else begin
            unique case (state_r)
                bfc_pkg::ST_IDLE: begin
                    if (cmd_wr) begin
                        state_r <= bfc_pkg::ST_EXEC;
                        cnt_r   <= bfc_pkg::CYC_ONE;
                    end
                end
                bfc_pkg::ST_EXEC: begin
                    if (done) begin
                        state_r    <= bfc_pkg::ST_IDLE;
                        last_cyc_r <= need;
                    end else begin
                        cnt_r <= cnt_r + 3'd1;
                    end
                end
                default: state_r <= bfc_pkg::ST_IDLE;
            endcase
        end
    end

    // Command fields; a command written while busy is dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_r  <= 5'd0;
            bit_r <= 3'd0;
            two_r <= 1'b0;
            k_r   <= 12'h000;
        end else if (cmd_wr) begin
            op_r  <= hwdata[bfc_pkg::CMD_OP_LSB +: 5];
            bit_r <= hwdata[bfc_pkg::CMD_BIT_LSB +: 3];
            two_r <= hwdata[bfc_pkg::CMD_TWO_POS];
            k_r   <= hwdata[bfc_pkg::CMD_K_LSB +: 12];
        end
    end

    // Operand, pointer, PC and flag registers; frozen while executing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_r   <= 8'h00;
            rr_r   <= 8'h00;
            io_r   <= 8'h00;
            z_r    <= 16'h0000;
            stk_r  <= 16'h0000;
            pc_r   <= bfc_pkg::PC_RST;
            flags_r <= bfc_pkg::FLG_RST;
            link_r  <= 16'h0000;
        end else if (done) begin
            pc_r    <= pc_nxt;
            flags_r <= flags_nxt;
            // Calls keep the address after the call for a later return
            if (op_r == bfc_pkg::relative_call_op || op_r == bfc_pkg::indirect_call_op) begin
                link_r <= pc_r + 16'h0001;
            end
        end else if (wr_pend_r && !busy) begin
            unique case (acc_addr_r)
                bfc_pkg::ADDR_OPND: begin
                    rd_r <= hwdata[bfc_pkg::OPND_RD_LSB +: 8];
                    rr_r <= hwdata[bfc_pkg::OPND_RR_LSB +: 8];
                    io_r <= hwdata[bfc_pkg::OPND_IO_LSB +: 8];
                end
                bfc_pkg::ADDR_PTR: begin
                    z_r   <= hwdata[bfc_pkg::PTR_Z_LSB +: 16];
                    stk_r <= hwdata[bfc_pkg::PTR_STK_LSB +: 16];
                end
                bfc_pkg::ADDR_PC:   pc_r   <= hwdata[15:0];
                bfc_pkg::ADDR_FLG:  flags_r <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    // Read data mux, registered in the wait cycle; unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_pend_r) begin
            unique case (acc_addr_r)
                bfc_pkg::ADDR_CMD:  hrdata_r <= {4'h0, k_r, 3'b000, two_r, 1'b0, bit_r,
                                                 3'b000, op_r};
                bfc_pkg::ADDR_OPND: hrdata_r <= {8'h00, io_r, rr_r, rd_r};
                bfc_pkg::ADDR_PTR:  hrdata_r <= {stk_r, z_r};
                bfc_pkg::ADDR_PC:   hrdata_r <= {16'h0000, pc_r};
                bfc_pkg::ADDR_FLG:  hrdata_r <= {24'h00_0000, flags_r};
                bfc_pkg::ADDR_STAT: hrdata_r <= {link_r, 9'h000, last_cyc_r, 3'b000, busy};
                default:            hrdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp     = 1'b0; // Always OKAY; constant needs no flop

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_launch;
        cmd_wr;
    endsequence
    sequence s_finish(logic [2:0] n);
        done && need == n;
    endsequence

    branch_target_a: assert property (done && is_branch && taken |=>
        pc_r == $past(rel_tgt) && last_cyc_r == 3'd2 && flags_r == $past(flags_r))
        else $error("taken branch target or timing wrong");
    branch_fall_a: assert property (done && is_branch && !taken |=>
        pc_r == $past(pc_r) + 16'h0001 && last_cyc_r == 3'd1)
        else $error("untaken branch did not fall through in one cycle");
    ind_jump_a: assert property (s_launch ##1 (op_r == 5'd1) |->
        ##1 s_finish(3'd2) ##1 (pc_r == $past(z_r, 1) && !busy))
        else $error("indirect jump not loaded from pointer in two cycles");
    ind_call_a: assert property (done && op_r == 5'd3 |=>
        pc_r == $past(z_r) && link_r == $past(pc_r) + 16'h0001 && last_cyc_r == 3'd3
        && flags_r == $past(flags_r))
        else $error("indirect call wrong");
    skip_taken_a: assert property (done && is_skip && taken |=>
        pc_r == $past(pc_r) + ($past(two_r) ? 16'h0003 : 16'h0002)
        && last_cyc_r == ($past(two_r) ? 3'd3 : 3'd2) && flags_r == $past(flags_r))
        else $error("skip advanced wrongly");
    cmp_one_a: assert property (s_launch ##1 is_cmp |-> done ##1
        (flags_r[bfc_pkg::FLAG_C] == $past(cc) && flags_r[bfc_pkg::FLAG_Z] == $past(cz)
        && pc_r == $past(pc_r) + 16'h0001))
        else $error("compare flags or timing wrong");
    rel_jump_a: assert property (done && op_r == 5'd0 |-> cnt_r == 3'd2 ##1
        pc_r == $past(rel_tgt))
        else $error("relative jump wrong");
    return_flow_a: assert property (done && op_r == 5'd5 |-> cnt_r == 3'd4 ##1
        pc_r == $past(stk_r) && flags_r[bfc_pkg::FLAG_I])
        else $error("interrupt return wrong");
    equal_branch_a: assert property (busy && op_r == 5'd16 |->
        taken == flags_r[bfc_pkg::FLAG_Z])
        else $error("equality branch condition wrong");
    busy_span_a: assert property (s_launch |=> busy && cnt_r == 3'd1)
        else $error("busy not raised after command");

endmodule : bfc_flow
`default_nettype wire

/* File: verif/bfc_prog_mem.sv */
// Program memory model: supplies the branch instruction word fetched for one operation
`timescale 1ns/1ps
`default_nettype none
module bfc_prog_mem (
    // Fetch address: the operation code indexes the word
    input  wire logic [4:0]  fetch_op,
    // Instruction word in command register layout
    output logic      [31:0] fetch_word
);
    // Offset 5, bit index from the low code bits, single-word successor
    assign fetch_word = {4'h0, 12'h005, 3'h0, 1'b0, 1'b0, fetch_op[2:0], 3'h0, fetch_op};
endmodule : bfc_prog_mem
`default_nettype wire

/* File: verif/tb_branch_compare_flow_control.sv */
// Self-checking bench of the branch, compare and flow-control unit
`timescale 1ns/1ps
`default_nettype none
module tb_branch_compare_flow_control;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, d, st;
    logic [1:0]  htrans = 0;
    logic        hreadyout, hresp;
    logic [4:0]  fetch_op = 0;
    logic [31:0] fetch_word;
    int mismatches = 0, comparisons = 0, cycles = 0;
    // ------------------------------------------------------------
    // Clock, reset, timeout
    // ------------------------------------------------------------
    always #12.5 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    bfc_flow DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));
    bfc_prog_mem PMEM (.fetch_op(fetch_op), .fetch_word(fetch_word));
    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // Address phase held until hready, then data phase held until hready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00; hsel <= 0; hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : xfer
    function automatic logic [31:0] mk(input logic [4:0] op, input logic [11:0] k,
                                       input logic [2:0] b, input logic two);
        return {4'h0, k, 3'h0, two, 1'b0, b, 3'h0, op};
    endfunction : mk
    // Load operands, issue, poll busy, then judge PC, flags and cycle count
    task automatic run(input logic [31:0] cmd, opnd, ptr, pc, flg, epc, esr, ecyc);
        xfer(1, bfc_pkg::ADDR_OPND, opnd); xfer(1, bfc_pkg::ADDR_PTR, ptr);
        xfer(1, bfc_pkg::ADDR_PC, pc); xfer(1, bfc_pkg::ADDR_FLG, flg);
        xfer(1, bfc_pkg::ADDR_CMD, cmd);
        repeat (20) begin
            xfer(0, bfc_pkg::ADDR_STAT, 0);
            if (d[0] === 1'b0) break;
        end
        st = d;
        // A poll that never saw busy fall must not pass quietly
        chk("busy", 32'h0, {31'h0, st[0]});
        chk("cycles", ecyc, {29'h0, st[6:4]});
        xfer(0, bfc_pkg::ADDR_PC, 0); chk("pc", epc, d);
        xfer(0, bfc_pkg::ADDR_FLG, 0); chk("flags", esr, d);
    endtask : run
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        xfer(0, bfc_pkg::ADDR_PC, 0); chk("pc_rst", 32'h0, d);
        xfer(0, bfc_pkg::ADDR_FLG, 0); chk("flags_rst", 32'h0, d);
        xfer(0, bfc_pkg::ADDR_STAT, 0); chk("stat_rst", 32'h0, d);
        xfer(1, 8'h20, 32'hFFFF_FFFF); xfer(0, 8'h20, 0); chk("unmapped", 32'h0, d);
        // Read-back of the operand and pointer registers; operand top byte reads zero
        xfer(1, bfc_pkg::ADDR_PTR, 32'hA5A5_5A5A); xfer(0, bfc_pkg::ADDR_PTR, 0);
        chk("ptr_rb", 32'hA5A5_5A5A, d);
        xfer(1, bfc_pkg::ADDR_OPND, 32'hFFFF_FFFF); xfer(0, bfc_pkg::ADDR_OPND, 0);
        chk("opnd_rb", 32'h00FF_FFFF, d);
    endtask : t_reset
    task automatic t_flow();
        run(mk(bfc_pkg::relative_jump_op, 12'hFFE, 0, 0), 0, 0, 32'h100, 32'h81, 32'hFF, 32'h81, 2);
        run(mk(bfc_pkg::relative_call_op, 12'h003, 0, 0), 0, 0, 32'h200, 32'h0, 32'h204, 0, 3);
        chk("link_addr", 32'h201, {16'h0, st[31:16]});
        xfer(0, bfc_pkg::ADDR_CMD, 0);
        chk("cmd_rb", mk(bfc_pkg::relative_call_op, 12'h003, 0, 0), d);
        run(mk(bfc_pkg::indirect_jump_op, 0, 0, 0), 0, 32'h1234, 32'h40, 32'h3F, 32'h1234, 32'h3F, 2);
        run(mk(bfc_pkg::indirect_call_op, 0, 0, 0), 0, 32'h1234, 32'h40, 32'h5A, 32'h1234, 32'h5A, 3);
        chk("call_link", 32'h41, {16'h0, st[31:16]});
        run(mk(bfc_pkg::subroutine_return_op, 0, 0, 0), 0, 32'h0456_0000, 32'h9, 32'h5, 32'h456, 32'h5, 4);
        run(mk(bfc_pkg::interrupt_return_op, 0, 0, 0), 0, 32'h0456_0000, 32'h9, 32'h5, 32'h456, 32'h85, 4);
    endtask : t_flow
    task automatic t_compare();
        run(mk(bfc_pkg::compare_regs_op, 0, 0, 0), 32'h2010, 0, 32'h10, 32'h0, 32'h11, 32'h05, 1);
        run(mk(bfc_pkg::compare_immediate_op, 0, 0, 0), 32'h3838, 0, 32'h10, 32'h10, 32'h11, 32'h12, 1);
        run(mk(bfc_pkg::compare_regs_carry_op, 0, 0, 0), 32'h3738, 0, 32'h10, 32'h03, 32'h11, 32'h02, 1);
    endtask : t_compare
    task automatic t_skip();
        run(mk(bfc_pkg::compare_skip_equal_op, 0, 0, 1), 32'h4242, 0, 32'h10, 32'h0, 32'h13, 0, 3);
        run(mk(bfc_pkg::compare_skip_equal_op, 0, 0, 0), 32'h4342, 0, 32'h10, 32'h0, 32'h11, 0, 1);
        run(mk(bfc_pkg::skip_reg_bit_set_op, 0, 3, 0), 32'h0800, 0, 32'h10, 32'h0, 32'h12, 0, 2);
        run(mk(bfc_pkg::skip_reg_bit_clear_op, 0, 3, 0), 32'h0800, 0, 32'h10, 32'h0, 32'h11, 0, 1);
        run(mk(bfc_pkg::skip_io_bit_clear_op, 0, 7, 1), 32'h0, 0, 32'h10, 32'hFF, 32'h13, 32'hFF, 3);
        run(mk(bfc_pkg::skip_io_bit_set_op, 0, 7, 0), 32'h0, 0, 32'h10, 32'hFF, 32'h11, 32'hFF, 1);
    endtask : t_skip
    // Every flag branch against two flag patterns complementary in bits 0 to 6, and all ones
    task automatic t_branch();
        logic [7:0] s;
        logic       tk;
        for (int i = 14; i < 32; i++) begin
            for (int p = 0; p < 3; p++) begin
                // All ones makes N xor V zero and sets the top flag bit
                s = (p == 2) ? 8'hFF : (p == 1) ? 8'h55 : 8'h2A;
                fetch_op <= 5'(i);
                @(posedge hclk);
                case (i)
                    14: tk = s[i[2:0]]; 15: tk = !s[i[2:0]];
                    16: tk = s[1]; 17: tk = !s[1]; 18, 21: tk = s[0]; 19, 20: tk = !s[0];
                    22: tk = s[2]; 23: tk = !s[2]; 24: tk = !(s[2] ^ s[3]); 25: tk = s[2] ^ s[3];
                    26: tk = s[5]; 27: tk = !s[5]; 28: tk = s[6]; 29: tk = !s[6];
                    30: tk = s[3]; default: tk = !s[3];
                endcase
                run(fetch_word, 0, 0, 32'h10, {24'h0, s}, tk ? 32'h16 : 32'h11, {24'h0, s},
                    tk ? 2 : 1);
            end
        end
    endtask : t_branch
    task automatic end_of_test();
        if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        t_reset(); t_flow(); t_compare(); t_skip(); t_branch();
        end_of_test();
    end
endmodule : tb_branch_compare_flow_control
`default_nettype wire
